// [core/iecs_pkg.sv]
// Constants shared by the ion experiment command sequencer
package iecs_pkg;
   localparam int         CMD_W          = 4;
   localparam int         WORD_W         = 10;
   localparam int         CNT_W          = 10;
   // Four-bit command codes; zero means no command
   localparam logic [3:0] CMD_NONE       = 4'h0;
   localparam logic [3:0] CMD_GP_ONOFF   = 4'h1;
   localparam logic [3:0] CMD_FRAME_RST  = 4'h2;
   localparam logic [3:0] CMD_CAL_FORCE  = 4'h3;
   localparam logic [3:0] CMD_MASTER_RST = 4'h4;
   localparam logic [3:0] CMD_PROG_LAST  = 4'h7;
   localparam logic [3:0] CMD_HV_HI      = 4'h8;
   localparam logic [3:0] CMD_HV_LO      = 4'h9;
   localparam logic [3:0] CMD_HV_VF      = 4'hA;
   localparam logic [3:0] CMD_HV_GAUGE   = 4'hB;
   localparam logic [3:0] CMD_HV_CHAN    = 4'hC;
   // Command lines that also feed the one-time register
   localparam int         OT_SEAL_LINE   = 2;
   localparam int         OT_DUST_LINE   = 3;
   // Programmer and ground-plane stepper
   localparam logic [6:0] PROG_LAST      = 7'h7F;
   localparam logic [6:0] CAL_FIRST      = 7'h78;
   localparam logic [4:0] GP_LAST        = 5'h17;
   // Telemetry slots for science words and experiment frame length
   localparam logic [5:0] SLOT_A         = 6'h0F;
   localparam logic [5:0] SLOT_B         = 6'h1F;
   localparam logic [5:0] SLOT_C         = 6'h2F;
   localparam logic [5:0] SLOT_D         = 6'h38;
   localparam logic [5:0] SLOT_E         = 6'h3F;
   localparam logic [3:0] SWORD_LAST     = 4'h9;
   localparam logic [4:0] HV_RESET       = 5'h00;
endpackage : iecs_pkg

// [core/iecs_sequencer.sv]
// Command reception, programmer sequencing and science word output of the ion experiment
// Overview of operation
// - Four code lines select one of up to fifteen command functions.
// - Commands act only when the execute pulse arrives.
// - First pulse on line 2 is also caught in the one-time register.
// - Execute of a non-zero code also fires the pending one-time action.
// - Later pulses on that line leave the one-time register unchanged.
// - Exactly two one-time commands exist beside the routine ones.
// - Five 10-bit science words go out at slots 15, 31, 47, 56, 63.
// - Ten consecutive science words form one experiment frame.
// - Programmer runs 128 steps per cycle, then restarts.
// - Ground-plane stepper advances once per completed cycle.
// - Twenty-four cycles, one per ground-plane step, form one field.
// - Executed commands go to the programmer or the ion detection logic.
// - Programmer steps analyzers, velocity filter and ground plane.
// - Programmer gives calibration timing to the gauge.
// - Ion detections are counted per voltage step and handed on.
// - Results are converted, commutated and gated out to the host.
// - A parity bit covers each output science word.
// - Code lines latch into an input buffer, copied to mode buffer on execute.
// - A 128-state frame counter issues advance pulses.
module iecs_sequencer
   import iecs_pkg::*;
(
   input  wire logic              clk_sys_in,
   input  wire logic              rstn_in,
   input  wire logic [CMD_W-1:0]  cmd_line_in,
   input  wire logic              cmd_exec_in,
   input  wire logic              shift_in,
   input  wire logic              demand_in,
   input  wire logic              frame_mark_in,
   input  wire logic              even_mark_in,
   input  wire logic              ion_hi_in,
   input  wire logic              ion_lo_in,
   input  wire logic              gauge_in,
   input  wire logic [WORD_W-1:0] adc_in,
   input  wire logic              sci_ready_in,
   output logic                   sci_valid_out,
   output logic [WORD_W-1:0]      sci_word_out,
   output logic                   sci_parity_out,
   output logic                   seal_break_out,
   output logic                   dust_cover_out,
   output logic [6:0]             prog_step_out,
   output logic [4:0]             gp_step_out,
   output logic                   step_adv_out,
   output logic                   cal_out,
   output logic [4:0]             hv_en_out,
   output logic [CMD_W-1:0]       mode_out
);

   function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v, input logic hit);
      sat_inc = (hit && v != {CNT_W{1'b1}}) ? v + 1'b1 : v;
   endfunction : sat_inc

   function automatic logic is_slot(input logic [5:0] s);
      is_slot = (s == SLOT_A) || (s == SLOT_B) || (s == SLOT_C) || (s == SLOT_D) || (s == SLOT_E);
   endfunction : is_slot

   // Two-stage synchronisers for all pins except sci_ready_in and rstn_in
   localparam int SW = CMD_W + 8 + WORD_W;
   logic [SW-1:0] sync1;
   logic [SW-1:0] sync2;
   logic [8+CMD_W-1:0] prev;
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         sync1 <= '0;
         sync2 <= '0;
         prev  <= '0;
      end else begin
         sync1 <= {adc_in, cmd_line_in, cmd_exec_in, shift_in, demand_in, frame_mark_in,
                   even_mark_in, ion_hi_in, ion_lo_in, gauge_in};
         sync2 <= sync1;
         prev  <= sync2[8+CMD_W-1:0];
      end
   end

   logic [WORD_W-1:0] adc_s;
   logic [CMD_W-1:0]  line_p;
   logic exec_p, shift_p, demand_p, fmark_p, emark_p, hi_p, lo_p, gauge_p;
   logic [8+CMD_W-1:0] rise;
   always_comb begin
      rise = sync2[8+CMD_W-1:0] & ~prev;
      adc_s = sync2[SW-1:8+CMD_W];
      {line_p, exec_p, shift_p, demand_p, fmark_p, emark_p, hi_p, lo_p, gauge_p} = rise;
   end

   // Command state
   logic [CMD_W-1:0] in_buf, next_in_buf, mode_buf, next_mode_buf;
   logic [1:0] ot_seen, next_ot_seen, ot_pend, next_ot_pend;
   logic seal, next_seal, dust, next_dust;
   logic gp_en, next_gp_en, cal_force, next_cal_force;
   logic [4:0] hv_en, next_hv_en;
   logic frame_rst, next_frame_rst, master_rst, next_master_rst;
   logic [CMD_W-1:0] code;

   always_comb begin
      code            = in_buf | line_p;
      next_in_buf     = code;
      next_mode_buf   = mode_buf;
      next_ot_seen    = ot_seen;
      next_ot_pend    = ot_pend;
      next_seal       = 1'b0;
      next_dust       = 1'b0;
      next_gp_en      = gp_en;
      next_cal_force  = cal_force;
      next_hv_en      = hv_en;
      next_frame_rst  = 1'b0;
      next_master_rst = 1'b0;
      // First pulse only on each one-time line; later ones ignored
      if (line_p[OT_SEAL_LINE] && !ot_seen[0]) begin
         next_ot_seen[0] = 1'b1;
         next_ot_pend[0] = 1'b1;
      end
      if (line_p[OT_DUST_LINE] && !ot_seen[1]) begin
         next_ot_seen[1] = 1'b1;
         next_ot_pend[1] = 1'b1;
      end
      if (exec_p) begin
         next_in_buf   = '0;
         next_mode_buf = code;
         if (code != CMD_NONE) begin
            next_seal    = next_ot_pend[0];
            next_dust    = next_ot_pend[1];
            next_ot_pend = 2'b00;
         end
         // Codes up to 7 steer the programmer, above that the detectors
         unique case (code)
            CMD_GP_ONOFF:   next_gp_en      = !gp_en;
            CMD_FRAME_RST:  next_frame_rst  = 1'b1;
            CMD_CAL_FORCE:  next_cal_force  = !cal_force;
            CMD_MASTER_RST: next_master_rst = 1'b1;
            CMD_HV_HI:      next_hv_en[0]   = !hv_en[0];
            CMD_HV_LO:      next_hv_en[1]   = !hv_en[1];
            CMD_HV_VF:      next_hv_en[2]   = !hv_en[2];
            CMD_HV_GAUGE:   next_hv_en[3]   = !hv_en[3];
            CMD_HV_CHAN:    next_hv_en[4]   = !hv_en[4];
            default:        next_mode_buf   = code;
         endcase
      end
      if (master_rst) begin
         next_gp_en     = 1'b0;
         next_cal_force = 1'b0;
         next_hv_en     = HV_RESET;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         in_buf     <= '0;
         mode_buf   <= '0;
         ot_seen    <= '0;
         ot_pend    <= '0;
         seal       <= 1'b0;
         dust       <= 1'b0;
         gp_en      <= 1'b0;
         cal_force  <= 1'b0;
         hv_en      <= HV_RESET;
         frame_rst  <= 1'b0;
         master_rst <= 1'b0;
      end else begin
         in_buf     <= next_in_buf;
         mode_buf   <= next_mode_buf;
         ot_seen    <= next_ot_seen;
         ot_pend    <= next_ot_pend;
         seal       <= next_seal;
         dust       <= next_dust;
         gp_en      <= next_gp_en;
         cal_force  <= next_cal_force;
         hv_en      <= next_hv_en;
         frame_rst  <= next_frame_rst;
         master_rst <= next_master_rst;
      end
   end

   // Programmer, ion counting and science word commutation
   logic [6:0] prog, next_prog;
   logic [4:0] gp, next_gp;
   logic adv, next_adv, cal, next_cal, shift_tog, next_shift_tog;
   logic [CNT_W-1:0] c_hi, c_lo, c_g, next_c_hi, next_c_lo, next_c_g;
   logic [CNT_W-1:0] l_hi, l_lo, l_g, next_l_hi, next_l_lo, next_l_g;
   logic [5:0] slot, next_slot;
   logic [3:0] sidx, next_sidx;
   logic [WORD_W-1:0] word;
   logic push, in_ready;

   always_comb begin
      next_prog      = prog;
      next_gp        = gp;
      next_adv       = 1'b0;
      next_shift_tog = shift_tog ^ shift_p;
      next_c_hi      = sat_inc(c_hi, hi_p);
      next_c_lo      = sat_inc(c_lo, lo_p);
      next_c_g       = sat_inc(c_g, gauge_p);
      next_l_hi      = l_hi;
      next_l_lo      = l_lo;
      next_l_g       = l_g;
      next_slot      = slot;
      next_sidx      = sidx;
      if (fmark_p) begin
         next_prog = (prog == PROG_LAST) ? 7'h00 : prog + 7'h01;
         next_adv  = 1'b1;
         next_l_hi = c_hi;
         next_l_lo = c_lo;
         next_l_g  = c_g;
         next_c_hi = '0;
         next_c_lo = '0;
         next_c_g  = '0;
         if (prog == PROG_LAST && gp_en) begin
            next_gp = (gp == GP_LAST) ? 5'h00 : gp + 5'h01;
         end
      end
      if (frame_rst || master_rst) begin
         next_prog = '0;
      end
      if (master_rst) begin
         next_gp = '0;
      end
      next_cal = (next_prog >= CAL_FIRST) || cal_force;
      // Telemetry word position; frame mark restarts it
      if (fmark_p) begin
         next_slot = '0;
      end else if (demand_p) begin
         next_slot = slot + 6'h01;
      end
      if (emark_p) begin
         next_sidx = '0;
      end else if (push) begin
         next_sidx = (sidx == SWORD_LAST) ? 4'h0 : sidx + 4'h1;
      end
      unique case (sidx)
         4'h0:    word = {3'b000, prog};
         4'h1:    word = {hv_en, gp};
         4'h2:    word = l_hi;
         4'h3:    word = l_lo;
         4'h4:    word = l_g;
         4'h5:    word = {shift_tog, mode_buf, ot_seen, cal, gp_en, cal_force};
         4'h6:    word = adc_s;
         default: word = {1'b1, 2'b00, prog};
      endcase
      // A refused word is retried at the next slot, so none is lost
      push = demand_p && is_slot(slot) && in_ready;
   end

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         prog      <= '0;
         gp        <= '0;
         adv       <= 1'b0;
         cal       <= 1'b0;
         shift_tog <= 1'b0;
         c_hi      <= '0;
         c_lo      <= '0;
         c_g       <= '0;
         l_hi      <= '0;
         l_lo      <= '0;
         l_g       <= '0;
         slot      <= '0;
         sidx      <= '0;
      end else begin
         prog      <= next_prog;
         gp        <= next_gp;
         adv       <= next_adv;
         cal       <= next_cal;
         shift_tog <= next_shift_tog;
         c_hi      <= next_c_hi;
         c_lo      <= next_c_lo;
         c_g       <= next_c_g;
         l_hi      <= next_l_hi;
         l_lo      <= next_l_lo;
         l_g       <= next_l_g;
         slot      <= next_slot;
         sidx      <= next_sidx;
      end
   end

   // Two-entry output buffer: output register plus skid register
   logic out_v, next_out_v, skid_v, next_skid_v;
   logic [WORD_W:0] out_d, next_out_d, skid_d, next_skid_d, in_d;
   always_comb begin
      in_d        = {^word, word};
      in_ready    = !skid_v;
      next_out_v  = out_v;
      next_out_d  = out_d;
      next_skid_v = skid_v;
      next_skid_d = skid_d;
      if (!out_v || sci_ready_in) begin
         if (skid_v) begin
            next_out_v  = 1'b1;
            next_out_d  = skid_d;
            next_skid_v = push;
            next_skid_d = in_d;
         end else begin
            next_out_v  = push;
            next_out_d  = push ? in_d : out_d;
         end
      end else if (push) begin
         next_skid_v = 1'b1;
         next_skid_d = in_d;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         out_v  <= 1'b0;
         out_d  <= '0;
         skid_v <= 1'b0;
         skid_d <= '0;
      end else begin
         out_v  <= next_out_v;
         out_d  <= next_out_d;
         skid_v <= next_skid_v;
         skid_d <= next_skid_d;
      end
   end

   always_comb begin
      sci_valid_out  = out_v;
      sci_word_out   = out_d[WORD_W-1:0];
      sci_parity_out = out_d[WORD_W];
      seal_break_out = seal;
      dust_cover_out = dust;
      prog_step_out  = prog;
      gp_step_out    = gp;
      step_adv_out   = adv;
      cal_out        = cal;
      hv_en_out      = hv_en;
      mode_out       = mode_buf;
   end

endmodule : iecs_sequencer

// [testbench/iecs_sequencer_assertions.sv]
// Port checks of the ion experiment command sequencer
module iecs_sequencer_assertions
   import iecs_pkg::*;
(
   input wire logic              clk_sys_in,
   input wire logic              rstn_in,
   input wire logic              cmd_exec_in,
   input wire logic              sci_ready_in,
   input wire logic              sci_valid_out,
   input wire logic [WORD_W-1:0] sci_word_out,
   input wire logic              sci_parity_out,
   input wire logic              seal_break_out,
   input wire logic              dust_cover_out,
   input wire logic [6:0]        prog_step_out,
   input wire logic [4:0]        gp_step_out,
   input wire logic              cal_out,
   input wire logic [CMD_W-1:0]  mode_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] ot_seen;
   logic [1:0] next_ot_seen;
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rstn_in);
   // Remembers which one-time action has already fired
   always_comb begin
      next_ot_seen = ot_seen | {dust_cover_out, seal_break_out};
   end
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ot_seen <= 2'h0;
      end else begin
         ot_seen <= next_ot_seen;
      end
   end
   sequence s_stall; sci_valid_out && !sci_ready_in; endsequence
   sequence s_hold; sci_valid_out && $stable(sci_word_out) && $stable(sci_parity_out); endsequence
   property p_hold; s_stall |=> s_hold; endproperty
   property p_parity; sci_valid_out |-> sci_parity_out == ^sci_word_out; endproperty
   property p_prog; $changed(prog_step_out) && prog_step_out != 7'h00 |-> prog_step_out == $past(prog_step_out) + 7'h01;
   endproperty
   property p_gp_step; $changed(gp_step_out) && gp_step_out != 5'h00
      |-> gp_step_out == $past(gp_step_out) + 5'h01 && prog_step_out == 7'h00; endproperty
   property p_gp_wrap; $changed(gp_step_out) && gp_step_out == 5'h00
      |-> ($past(gp_step_out) == GP_LAST && prog_step_out == 7'h00) || mode_out == CMD_MASTER_RST; endproperty
   property p_gp_range; gp_step_out <= GP_LAST; endproperty
   property p_cal; (prog_step_out >= CAL_FIRST) [*2] |-> cal_out; endproperty
   property p_mode; $changed(mode_out) |-> $past(cmd_exec_in, 3); endproperty
   property p_ot_once; (seal_break_out |-> !ot_seen[0]) and (dust_cover_out |-> !ot_seen[1]); endproperty
   property p_ot_exec; seal_break_out || dust_cover_out |-> mode_out != CMD_NONE; endproperty
   a_hold: assert property (p_hold) else $error("word moved while stalled");
   a_parity: assert property (p_parity) else $error("parity wrong");
   a_prog: assert property (p_prog) else $error("programmer skipped a step");
   a_gp_step: assert property (p_gp_step) else $error("ground plane step off cycle");
   a_gp_wrap: assert property (p_gp_wrap) else $error("ground plane wrapped early");
   a_gp_range: assert property (p_gp_range) else $error("ground plane step too high");
   a_cal: assert property (p_cal) else $error("calibration window missing");
   a_mode: assert property (p_mode) else $error("mode changed without execute");
   a_ot_once: assert property (p_ot_once) else $error("one-time action repeated");
   a_ot_exec: assert property (p_ot_exec) else $error("one-time action without command");
endmodule : iecs_sequencer_assertions
bind iecs_sequencer iecs_sequencer_assertions i_chk (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
   .cmd_exec_in(cmd_exec_in), .sci_ready_in(sci_ready_in), .sci_valid_out(sci_valid_out),
   .sci_word_out(sci_word_out), .sci_parity_out(sci_parity_out), .seal_break_out(seal_break_out),
   .dust_cover_out(dust_cover_out), .prog_step_out(prog_step_out), .gp_step_out(gp_step_out),
   .cal_out(cal_out), .mode_out(mode_out));

// [testbench/iecs_sink_model.sv]
// Science word receiver standing in for the host telemetry side
module iecs_sink_model (
   input  wire logic clk_sys_in,
   input  wire logic rstn_in,
   input  wire logic stall_in,
   input  wire logic fast_in,
   output logic      sci_ready_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] phase;
   logic [1:0] next_phase;
   always_comb begin
      next_phase = phase + 2'h1;
   end
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         phase <= 2'h0;
      end else begin
         phase <= next_phase;
      end
   end
   // Slow mode takes a word one cycle in four; a stall takes none
   assign sci_ready_out = !stall_in && (fast_in || phase == 2'h3);
endmodule : iecs_sink_model

// [testbench/tb_top.sv]
// Self-checking bench of the ion experiment command sequencer
module tb_top
   import iecs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_in, rstn_in, cmd_exec_in, stall, fast, sci_ready_in, sci_valid_out, sci_parity_out;
   logic seal_break_out, dust_cover_out, cal_out, step_adv_out;
   logic [3:0]  cmd_line_in, mode_out;
   logic [6:0]  strb; // shift, gauge, lo, hi, even mark, frame mark, demand
   logic [9:0]  adc_in, sci_word_out;
   logic [6:0]  prog_step_out, e_prog;
   logic [4:0]  gp_step_out, hv_en_out, e_gp, e_hv;
   logic        e_gpen, e_shift, e_calf;
   logic [1:0]  e_ot;
   logic [3:0]  e_mode;
   logic [19:0] expq[$];
   int          miscompares, checks_done, cycles, n_seal, n_dust, n_adv, idx;
   int          cnt[3];
   iecs_sequencer i_dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .cmd_line_in(cmd_line_in),
      .cmd_exec_in(cmd_exec_in), .shift_in(strb[6]), .demand_in(strb[0]), .frame_mark_in(strb[1]),
      .even_mark_in(strb[2]), .ion_hi_in(strb[3]), .ion_lo_in(strb[4]), .gauge_in(strb[5]),
      .adc_in(adc_in), .sci_ready_in(sci_ready_in), .sci_valid_out(sci_valid_out),
      .sci_word_out(sci_word_out), .sci_parity_out(sci_parity_out), .seal_break_out(seal_break_out),
      .dust_cover_out(dust_cover_out), .prog_step_out(prog_step_out), .gp_step_out(gp_step_out),
      .step_adv_out(step_adv_out), .cal_out(cal_out), .hv_en_out(hv_en_out), .mode_out(mode_out));
   iecs_sink_model i_sink (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .stall_in(stall),
      .fast_in(fast), .sci_ready_out(sci_ready_in));
   task automatic complete_run();
      if (miscompares == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : complete_run
   task automatic cmp(input string what, input logic [9:0] exp, input logic [9:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   task automatic cmp_word(input logic [9:0] got);
      logic [19:0] e;
      checks_done++;
      e = (expq.size() > 0) ? expq.pop_front() : {10'h3FF, ~got};
      if ((got & e[19:10]) !== (e[9:0] & e[19:10])) begin
         miscompares++;
         $display("Error science word expected %h seen %h", e[9:0], got);
      end
   endtask : cmp_word
   function automatic logic [19:0] exp_word(input int i);
      case (i)
         0: return {10'h3FF, 3'h0, e_prog};
         1: return {10'h3FF, e_hv, e_gp};
         2, 3, 4: return {10'h3FF, 10'(cnt[i-2])};
         5: return {10'h3FF, e_shift, e_mode, e_ot, 1'((e_prog >= CAL_FIRST) || e_calf), e_gpen, e_calf};
         6: return {10'h3FF, adc_in};
         default: return {10'h3FF, 3'h4, e_prog};
      endcase
   endfunction : exp_word
   task automatic pulse(input int b);
      @(posedge clk_sys_in);
      strb[b] <= 1'b1;
      repeat (3) @(posedge clk_sys_in);
      strb[b] <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
   endtask : pulse
   task automatic do_cmd(input logic [3:0] c);
      @(posedge clk_sys_in);
      cmd_line_in <= c;
      repeat (3) @(posedge clk_sys_in);
      cmd_line_in <= 4'h0;
      repeat (3) @(posedge clk_sys_in);
      cmd_exec_in <= 1'b1;
      repeat (3) @(posedge clk_sys_in);
      cmd_exec_in <= 1'b0;
      repeat (4) @(posedge clk_sys_in);
      #1;
      e_mode = c;
      e_ot = e_ot | {c[OT_DUST_LINE], c[OT_SEAL_LINE]};
      if (c == CMD_GP_ONOFF) e_gpen = !e_gpen;
      if (c == CMD_CAL_FORCE) e_calf = !e_calf;
      if (c == CMD_FRAME_RST) e_prog = '0;
      if (c == CMD_MASTER_RST) {e_gpen, e_calf, e_hv, e_prog, e_gp} = '0;
      if (c >= CMD_HV_HI && c <= CMD_HV_CHAN) e_hv[c-CMD_HV_HI] = !e_hv[c-CMD_HV_HI];
      cmp("mode", 10'(c), 10'(mode_out));
      cmp("hv enables", 10'(e_hv), 10'(hv_en_out));
      cmp("prog after command", 10'(e_prog), 10'(prog_step_out));
      cmp("cal after command", 10'((e_prog >= CAL_FIRST) || e_calf), 10'(cal_out));
   endtask : do_cmd
   // One telemetry frame of demands; slots taken while the buffer is full are lost
   task automatic frame(input logic even, input logic stalled);
      pulse(1);
      e_prog = e_prog + 7'h01;
      if (even) pulse(2);
      if (even) idx = 0;
      stall <= stalled;
      for (int k = 0; k < 64; k++) begin
         if (k == 50) stall <= 1'b0;
         if (k inside {15, 31, 47, 56, 63} && expq.size() < 2) begin
            expq.push_back(exp_word(idx));
            idx = (idx + 1) % 10;
         end
         pulse(0);
      end
   endtask : frame
   initial begin
      clk_sys_in = 1'b0;
      forever #10 clk_sys_in = ~clk_sys_in;
   end
   always @(posedge clk_sys_in) begin
      cycles++;
      if (rstn_in === 1'b1 && sci_valid_out === 1'b1 && sci_ready_in === 1'b1) cmp_word(sci_word_out);
      if (seal_break_out === 1'b1) n_seal++;
      if (dust_cover_out === 1'b1) n_dust++;
      if (step_adv_out === 1'b1) n_adv++;
      if (cycles == 40000) begin
         miscompares++;
         complete_run();
      end
   end
   initial begin
      void'($urandom(71663));
      {rstn_in, cmd_exec_in, cmd_line_in, strb, stall, e_gpen, e_hv, e_prog, e_gp} = '0;
      {e_shift, e_calf, e_ot, e_mode} = '0;
      fast = 1'b1;
      adc_in = 10'($urandom);
      repeat (3) @(posedge clk_sys_in);
      rstn_in <= 1'b1;
      repeat (2) @(posedge clk_sys_in);
      for (int c = 1; c < 16; c++) do_cmd(4'(c));
      do_cmd(CMD_NONE);
      cmp("seal pulses", 10'h001, 10'(n_seal));
      cmp("dust pulses", 10'h001, 10'(n_dust));
      do_cmd(CMD_GP_ONOFF);
      for (int i = 0; i < 3072; i++) begin
         pulse(1);
         e_prog = e_prog + 7'h01;
         if (e_prog == 7'h00 && e_gpen) e_gp = (e_gp == GP_LAST) ? 5'h00 : e_gp + 5'h01;
         #1;
         cmp("prog", 10'(e_prog), 10'(prog_step_out));
         cmp("ground plane", 10'(e_gp), 10'(gp_step_out));
         cmp("cal", 10'(e_prog >= CAL_FIRST), 10'(cal_out));
         cmp("advance pulses", 10'(i + 1), 10'(n_adv));
      end
      for (int j = 0; j < 3; j++) begin
         cnt[j] = $urandom_range(12);
         repeat (cnt[j]) pulse(3 + j);
      end
      pulse(6);
      e_shift = 1'b1;
      frame(1'b1, 1'b0);
      cnt = '{0, 0, 0};
      fast = 1'b0;
      frame(1'b0, 1'b0);
      frame(1'b0, 1'b1);
      do_cmd(CMD_FRAME_RST);
      repeat (20) @(posedge clk_sys_in);
      cmp("words left", 10'h000, 10'(expq.size()));
      complete_run();
   end
endmodule : tb_top
